// file: hw/dsam_monitor.sv
// Dual sensor alarm monitor: two static/dynamic threshold alarms
`timescale 1ns/1ps
`default_nettype none

module dsam_monitor
    import dsam_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Register values held by the register interface
    input wire logic [15:0] alarm_configuration,
    input wire logic [15:0] first_alarm_threshold,
    input wire logic [15:0] second_alarm_threshold,
    input wire logic [7:0] first_alarm_sample_count,
    input wire logic [7:0] second_alarm_sample_count,
    // Sensor data, one strobe per internal sample
    input wire logic sample_valid,
    input wire dsam_samples_t raw_samples,
    input wire dsam_samples_t filtered_samples,
    // Alarm reporting
    output logic [1:0] diagnostic_flags,
    output logic first_digital_io_line,
    output logic first_digital_io_line_oe,
    output logic second_digital_io_line,
    output logic second_digital_io_line_oe
);

    // -------------------------------------------------------------
    // Source selection
    // -------------------------------------------------------------
    dsam_samples_t src;
    logic [3:0] sel [2];
    logic dyn [2];
    logic pol [2];
    logic [15:0] thr [2];
    logic [7:0] cnt [2];
    logic [1:0] hit_nxt;
    logic [7:0] wr_ptr_r;
    logic [1:0] flags_r;

    assign src = alarm_configuration[DSAM_FILT_BIT] ?
                 filtered_samples : raw_samples;
    assign sel[0] = alarm_configuration[DSAM_SRC1_HI:DSAM_SRC1_LO];
    assign sel[1] = alarm_configuration[DSAM_SRC2_HI:DSAM_SRC2_LO];
    assign dyn[0] = alarm_configuration[DSAM_DYN1_BIT];
    assign dyn[1] = alarm_configuration[DSAM_DYN2_BIT];
    assign pol[0] = alarm_configuration[DSAM_POL1_BIT];
    assign pol[1] = alarm_configuration[DSAM_POL2_BIT];
    assign thr[0] = first_alarm_threshold;
    assign thr[1] = second_alarm_threshold;
    assign cnt[0] = first_alarm_sample_count;
    assign cnt[1] = second_alarm_sample_count;

    // -------------------------------------------------------------
    // Sample history, written once per sample
    // -------------------------------------------------------------
    // One history of all six channels is shared by both alarms, so a
    // change of source selection takes effect with full history.
    // Limitation: the history is not reset, so a dynamic alarm gives
    // meaningless results until as many samples as its count have
    // been seen since reset or since the filter selection changed.
    dsam_samples_t hist [DSAM_HISTORY_DEPTH];

    always_ff @(posedge sys_clk) begin
        if (sample_valid) begin
            hist[wr_ptr_r] <= src;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_ptr_r <= 8'h00;
        end else if (sample_valid) begin
            wr_ptr_r <= wr_ptr_r + 8'h01;
        end
    end

    // -------------------------------------------------------------
    // Per-alarm comparison
    // -------------------------------------------------------------
    // Both alarms share one datapath shape; only the register fields
    // that steer them differ.
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_alarm
            logic [7:0] depth;
            logic [7:0] rd_ptr;
            logic chan_ok;
            dsam_samples_t past;
            logic signed [15:0] cur;
            logic signed [15:0] old;
            logic signed [16:0] diff;
            logic signed [16:0] value;
            logic signed [16:0] limit;
            logic above;
            logic below;

            // Count zero treated as one sample back
            assign depth = (cnt[g] == 8'h00) ? 8'h01 : cnt[g];
            assign rd_ptr = wr_ptr_r - depth;
            assign past = hist[rd_ptr];

            // Codes above the last channel are refused, not wrapped
            assign chan_ok = (sel[g] != DSAM_SRC_OFF) &&
                             (sel[g] <= DSAM_SRC_MAX);

            // An explicit mux keeps every slice inside the word, even
            // for refused codes where an indexed slice would run off
            always_comb begin
                case (sel[g])
                    4'h1: begin
                        cur = src.x_rate_output;
                        old = past.x_rate_output;
                    end
                    4'h2: begin
                        cur = src.y_rate_output;
                        old = past.y_rate_output;
                    end
                    4'h3: begin
                        cur = src.z_rate_output;
                        old = past.z_rate_output;
                    end
                    4'h4: begin
                        cur = src.x_accel_output;
                        old = past.x_accel_output;
                    end
                    4'h5: begin
                        cur = src.y_accel_output;
                        old = past.y_accel_output;
                    end
                    4'h6: begin
                        cur = src.z_accel_output;
                        old = past.z_accel_output;
                    end
                    default: begin
                        cur = 16'sh0000;
                        old = 16'sh0000;
                    end
                endcase
            end

            // One extra bit so the change cannot wrap
            assign diff = 17'(cur) - 17'(old);
            // Static compares the current sample of the selected source, dynamic the change
            assign value = dyn[g] ? diff : 17'(cur);
            assign limit = 17'(signed'(thr[g]));
            assign above = value > limit;
            assign below = value < limit;
            assign hit_nxt[g] = chan_ok &&
                                (pol[g] ? above : below);
        end
    endgenerate

    // -------------------------------------------------------------
    // Status flags and indicator
    // -------------------------------------------------------------
    // Flags show the condition of the latest sample; they are not
    // sticky, so the host sees the live alarm state.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flags_r <= 2'b00;
        end else if (sample_valid) begin
            flags_r <= hit_nxt;
        end
    end

    assign diagnostic_flags = flags_r;

    // Line level follows the flags every cycle; the polarity is set
    // here so a new active level shows without waiting for a sample
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            first_digital_io_line <= 1'b0;
            second_digital_io_line <= 1'b0;
        end else begin
            first_digital_io_line <=
                (|flags_r) ~^ alarm_configuration[DSAM_IND_POL_BIT];
            second_digital_io_line <=
                (|flags_r) ~^ alarm_configuration[DSAM_IND_POL_BIT];
        end
    end

    // Indicator lines are driven only when enabled and routed; a
    // disabled indicator leaves both lines to their pull-ups
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            first_digital_io_line_oe <= 1'b0;
            second_digital_io_line_oe <= 1'b0;
        end else begin
            first_digital_io_line_oe <=
                alarm_configuration[DSAM_IND_EN_BIT] &&
                !alarm_configuration[DSAM_IND_SEL_BIT];
            second_digital_io_line_oe <=
                alarm_configuration[DSAM_IND_EN_BIT] &&
                alarm_configuration[DSAM_IND_SEL_BIT];
        end
    end

endmodule

`default_nettype wire

// file: hw/dsam_pkg.sv
// Package for the dual sensor alarm monitor: fields, codes, timing
package dsam_pkg;

    // -------------------------------------------------------------
    // Register reset values
    // -------------------------------------------------------------
    localparam logic [15:0] DSAM_CFG_RESET = 16'h0000;
    localparam logic [15:0] DSAM_THR_RESET = 16'h0000;
    localparam logic [7:0] DSAM_CNT_RESET = 8'h00;

    // -------------------------------------------------------------
    // Configuration field positions
    // -------------------------------------------------------------
    localparam int DSAM_SRC2_HI = 15;
    localparam int DSAM_SRC2_LO = 12;
    localparam int DSAM_SRC1_HI = 11;
    localparam int DSAM_SRC1_LO = 8;
    localparam int DSAM_DYN2_BIT = 7;
    localparam int DSAM_DYN1_BIT = 6;
    localparam int DSAM_POL2_BIT = 5;
    localparam int DSAM_POL1_BIT = 4;
    localparam int DSAM_FILT_BIT = 3;
    localparam int DSAM_IND_EN_BIT = 2;
    localparam int DSAM_IND_POL_BIT = 1;
    localparam int DSAM_IND_SEL_BIT = 0;

    // -------------------------------------------------------------
    // Source selection codes
    // -------------------------------------------------------------
    localparam logic [3:0] DSAM_SRC_OFF = 4'h0;
    localparam logic [3:0] DSAM_SRC_MAX = 4'h6;

    // -------------------------------------------------------------
    // Timing: internal sample rate is 819.2 samples per second
    // -------------------------------------------------------------
    localparam int DSAM_HISTORY_DEPTH = 256;

    // Six sensor channels, one 16-bit two's complement word each
    typedef struct packed {
        logic [15:0] z_accel_output;
        logic [15:0] y_accel_output;
        logic [15:0] x_accel_output;
        logic [15:0] z_rate_output;
        logic [15:0] y_rate_output;
        logic [15:0] x_rate_output;
    } dsam_samples_t;

endpackage

// file: tb/dsam_host_model.sv
// Host side: reads the indicator wires and reports an alarm
`timescale 1ns/1ps
`default_nettype none
module dsam_host_model (
    // Indicator pins
    input wire logic l1,
    input wire logic o1,
    input wire logic l2,
    input wire logic o2,
    // Host copy of the indicator setting
    input wire logic en,
    input wire logic pol,
    input wire logic sel,
    output logic alarm_seen
);
    // Lines carry pull-ups, so an undriven line reads high
    wire w1 = o1 ? l1 : 1'h1;
    wire w2 = o2 ? l2 : 1'h1;
    assign alarm_seen = en && ((sel ? w2 : w1) == pol);
endmodule
`default_nettype wire

// file: tb/dsam_monitor_asserts.sv
// Checker on the dual sensor alarm monitor ports
`timescale 1ns/1ps
`default_nettype none
module dsam_monitor_asserts
    import dsam_pkg::*;
(
    // Watched ports
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [15:0] alarm_configuration,
    input wire logic [15:0] second_alarm_threshold,
    input wire logic sample_valid,
    input wire dsam_samples_t filtered_samples,
    input wire logic [1:0] diagnostic_flags,
    input wire logic first_digital_io_line,
    input wire logic first_digital_io_line_oe,
    input wire logic second_digital_io_line_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire [15:0] c = alarm_configuration;
    wire [1:0] f = diagnostic_flags;
    a_flags_hold: assert property (!sample_valid |=> $stable(f))
        else $error("flags moved without a sample");
    a_off_one: assert property (sample_valid && c[11:8] == 0 |=> !f[0])
        else $error("disabled first alarm raised");
    a_off_two: assert property (sample_valid && c[15:12] > 6 |=> !f[1])
        else $error("bad source raised second alarm");
    a_oe_first: assert property (1 |=> first_digital_io_line_oe ==
        $past(c[2] & !c[0])) else $error("first line enable wrong");
    a_oe_second: assert property (1 |=> second_digital_io_line_oe ==
        $past(c[2] & c[0])) else $error("second line enable wrong");
    a_line_level: assert property (first_digital_io_line_oe |->
        first_digital_io_line == ($past(|f) ~^ $past(c[1])))
        else $error("indicator level wrong");
    a_static_two: assert property (sample_valid && c[15:12] == 6 &&
        !c[7] && !c[5] && c[3] |=> f[1] == $past($signed(
        filtered_samples.z_accel_output) < $signed(second_alarm_threshold)))
        else $error("static second alarm wrong");
    a_reset_quiet: assert property (disable iff (1'h0) srst |=>
        f == 0 && !first_digital_io_line_oe && !second_digital_io_line_oe)
        else $error("outputs active after reset");
endmodule
bind dsam_monitor dsam_monitor_asserts u_chk (.*);
`default_nettype wire

// file: tb/test_dsam_monitor.sv
// Self-checking bench for the dual sensor alarm monitor
`timescale 1ns/1ps
`default_nettype none
module test_dsam_monitor
    import dsam_pkg::*;
;
    logic sys_clk = 0, srst = 1, sv = 0, l1, o1, l2, o2, seen;
    logic [15:0] cfg = 0, t1 = 16'h0005, t2 = 16'h0005;
    logic [7:0] n1 = 0, n2 = 8'h02;
    logic [1:0] fl;
    dsam_samples_t raw = '0, fil = '0;
    int mismatches = 0, n_checks = 0, cyc = 0;
    initial forever #5 sys_clk = ~sys_clk;
    dsam_monitor DUT (.sys_clk(sys_clk), .srst(srst),
        .alarm_configuration(cfg), .first_alarm_threshold(t1),
        .second_alarm_threshold(t2), .first_alarm_sample_count(n1),
        .second_alarm_sample_count(n2), .sample_valid(sv),
        .raw_samples(raw), .filtered_samples(fil),
        .diagnostic_flags(fl), .first_digital_io_line(l1),
        .first_digital_io_line_oe(o1), .second_digital_io_line(l2),
        .second_digital_io_line_oe(o2));
    dsam_host_model host (.l1(l1), .o1(o1), .l2(l2), .o2(o2),
        .en(cfg[2]), .pol(cfg[1]), .sel(cfg[0]), .alarm_seen(seen));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // One sample on a single channel; lines settle two edges later
    task smp(input int ch, input logic [15:0] r, input logic [15:0] f);
        raw = '0;
        fil = '0;
        raw[ch*16 +: 16] = r;
        fil[ch*16 +: 16] = f;
        sv = 1;
        @(posedge sys_clk) #1 sv = 0;
        @(posedge sys_clk) #1;
    endtask
    task test_src;
        for (int k = 0; k < 8; k++) begin
            cfg = {4'(k), 4'(k), 8'h30};
            smp((k + 5) % 6, 16'h000a, 16'h0000);
            chk(fl, (k > 0 && k < 7) ? 2'h3 : 2'h0);
        end
        cfg = 16'h6600;
        smp(5, 16'hfffd, 16'h0000);
        chk(fl, 2'h3);
        smp(5, 16'h0005, 16'h0000);
        chk(fl, 2'h0);
        $display("source test done");
    endtask
    task test_filter;
        cfg = 16'h6608;
        smp(5, 16'hfffd, 16'h000a);
        chk(fl, 2'h0);
        smp(5, 16'h000a, 16'hfffd);
        chk(fl, 2'h3);
        $display("filter test done");
    endtask
    // First count is zero and acts as one; second looks two back
    task test_dyn;
        cfg = 16'h11f0;
        for (int i = 0; i < 5; i++) begin
            smp(0, i > 1 ? 16'h000a : 16'h0000, 16'h0000);
            if (i > 1) chk(fl, i == 2 ? 2'h3 : i == 3 ? 2'h2 : 2'h0);
        end
        $display("dynamic test done");
    endtask
    task test_ind;
        for (int m = 0; m < 16; m++) begin
            cfg = 16'h0110 | 16'(m[2:0]);
            smp(0, m[3] ? 16'h000a : 16'h0000, 16'h0000);
            chk({o1, o2}, {cfg[2] & !cfg[0], cfg[2] & cfg[0]});
            chk(seen, cfg[2] & m[3]);
        end
        $display("indicator test done");
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 500) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        #1 srst = 0;
        chk({o1, o2, fl}, 16'h0000);
        test_src();
        test_filter();
        test_dyn();
        test_ind();
        finish_test();
    end
endmodule
`default_nettype wire
